// [hdl/sepi_pkg.sv]
// constants for the encoder process-data interface
package sepi_pkg;
  // image byte k sits at bits [63-8k -: 8]
  localparam int POS_MSB = 63;
  localparam int POS_LSB = 32;
  localparam int FB_B4 = 31;
  localparam int FB_B5 = 23;
  localparam int CT_B4 = 31;
  // feedback byte 4 bits
  localparam int B4_HEARTBEAT = 7;
  localparam int B4_READY = 6;
  localparam int B4_CFG_FAULT = 5;
  localparam int B4_FRAME_FAULT = 4;
  localparam int B4_SUPPLY = 3;
  localparam int B4_INPUT = 2;
  localparam int B4_DOWN = 1;
  localparam int B4_UP = 0;
  // feedback byte 5 bits
  localparam int B5_HIT2 = 3;
  localparam int B5_HIT1 = 2;
  localparam int B5_LOAD_ERR = 1;
  localparam int B5_LOAD_STAT = 0;
  // control byte 4 bits
  localparam int C4_FAULT_ACK = 7;
  localparam int C4_LATCH_ACK = 6;
  localparam int C4_LOAD2 = 1;
  localparam int C4_LOAD1 = 0;
  localparam int FROZEN_BIT = 31;
  localparam int FAST_HB_BIT = 63;
  // sampling rate code is in 0.1 kHz steps, 0 means no limit
  localparam int RATE_MAX_CODE = 63;
  localparam int RATE_PERIOD_UNITS = 10000;
  // serial link
  localparam int FRAME_BITS = 25;
  localparam int LINK_PERIOD_NS = 32;
  localparam int LINK_HALF_BIT = 4;
  localparam int NS_PER_US = 1000;
  typedef enum logic [2:0] {
    SEPI_IDLE = 3'b001,
    SEPI_SHIFT = 3'b010,
    SEPI_GAP = 3'b100
  } sepi_link_e;
endpackage

// [hdl/sepi_top.sv]
// encoder readout process-data interface with its serial link end
// Operation
// [RL1] isochronous heartbeat inverts on each new reading
// [RL2] skipped cycles leave heartbeat unchanged
// [RL3] heartbeat byte4 bit7, fast mode byte0 bit7
// [RL4] rate code zero or 1..63, isochronous only
// [RL5] read encoder once every n cycles
// [RL6] idle gap of monoflop time between frames
// [RL7] encoder monoflop under 64 us, above bit
// [RL8] image halves transferred as consistent units
// [RL9] position dword, bit31 set while frozen
// [RL10] byte4 status and fault flags
// [RL11] byte5 threshold hit flags
// [RL12] byte5 load error and load status
// [RL13] unused feedback bits read zero
// [RL14] master writes threshold dword bytes 0-3
// [RL15] master acknowledges faults and latch
// [RL16] master requests threshold 1 or 2 load
// [RL17] master writes zero to spare bits
// [RL18] both load requests: error, no load
// [RL19] frame fault clears after cause gone, acknowledged
// [RL20] load status answers the load requests
// [RL21] feedback fields update once per cycle
`timescale 1ns/100ps
`default_nettype none
module sepi_top (
  input wire logic clk,
  input wire logic srst,
  input wire logic link_clk,
  input wire logic link_srst,
  input wire logic cycle_strobe,
  input wire logic [63:0] ctrl_image,
  output logic [63:0] fb_image,
  input wire logic iso_mode,
  input wire logic fast_mode,
  input wire logic heartbeat_en,
  input wire logic latch_en,
  input wire logic [5:0] rate_code,
  input wire logic [15:0] cycle_time_us,
  input wire logic [15:0] monoflop_us,
  input wire logic config_fault,
  input wire logic aux_input_pin,
  input wire logic supply_short_pin,
  output logic ssi_clk_out,
  input wire logic ssi_data_in
);
  // ****************************************
  // system-side state
  // ****************************************
  typedef struct packed {
    logic [31:0] thr1;
    logic [31:0] thr2;
    logic [31:0] pos;
    logic [31:0] frozen_pos;
    logic frozen;
    logic [23:0] acc;
    logic heartbeat;
    logic req_tgl;
    logic [15:0] mf_hold;
    logic [2:0] done_sync;
    logic [2:0] aux_sync;
    logic aux_lvl;
    logic [2:0] sup_sync;
    logic sup_lvl;
    logic frame_fault;
    logic last_frame_bad;
    logic supply_fault;
    logic load_stat;
    logic load_err;
    logic up;
    logic dn;
    logic [63:0] fb;
  } sepi_sys_s;

  typedef struct packed {
    sepi_pkg::sepi_link_e st;
    logic [2:0] req_sync;
    logic [2:0] dat_sync;
    logic dat_lvl;
    logic [4:0] bit_cnt;
    logic [2:0] div;
    logic sclk;
    logic [31:0] shreg;
    logic [31:0] data;
    logic err;
    logic done_tgl;
    logic [31:0] gap_ns;
  } sepi_link_s;

  sepi_sys_s s_reg, s_next;
  sepi_link_s l_reg, l_next;

  logic [5:0] rate_eff;
  logic [23:0] step;
  logic acquire;
  logic new_frame;
  logic [31:0] val;
  logic [31:0] shown;
  logic [7:0] b4;
  logic [7:0] b5;
  logic [7:0] ctl4;

  // ****************************************
  // processing cycle logic
  // ****************************************
  always_comb begin
    s_next = s_reg;
    // rate limit only acts in isochronous mode
    rate_eff = (iso_mode && rate_code <= 6'(sepi_pkg::RATE_MAX_CODE)) ? rate_code : 6'h00; // RL4
    step = 24'(cycle_time_us * rate_eff);
    // n = ceil(period/cycle) without a divider: read once the summed time reaches one period
    acquire = (rate_eff == 6'h00) || (s_reg.acc + step >= 24'(sepi_pkg::RATE_PERIOD_UNITS)); // RL5
    new_frame = s_reg.done_sync[2] != s_reg.done_sync[1];
    val = l_reg.data;
    ctl4 = ctrl_image[sepi_pkg::CT_B4 -: 8];
    s_next.done_sync = {s_reg.done_sync[1:0], l_reg.done_tgl};
    s_next.aux_sync = {s_reg.aux_sync[1:0], aux_input_pin};
    s_next.sup_sync = {s_reg.sup_sync[1:0], supply_short_pin};
    if (s_reg.aux_sync[1] == s_reg.aux_sync[2]) begin
      s_next.aux_lvl = s_reg.aux_sync[2];
    end
    if (s_reg.sup_sync[1] == s_reg.sup_sync[2]) begin
      s_next.sup_lvl = s_reg.sup_sync[2];
    end
    // frame results land here; link data is stable until the next request
    if (new_frame) begin
      s_next.last_frame_bad = l_reg.err;
      if (l_reg.err) begin
        s_next.frame_fault = 1'b1;
      end else begin
        s_next.pos = val;
        s_next.up = val > s_reg.pos;
        s_next.dn = val < s_reg.pos;
      end
    end
    if (latch_en && s_next.aux_lvl && !s_reg.aux_lvl && !s_reg.frozen) begin
      s_next.frozen = 1'b1;
      s_next.frozen_pos = s_reg.pos;
    end
    if (s_next.sup_lvl) begin
      s_next.supply_fault = 1'b1;
    end
    if (cycle_strobe) begin
      // control image taken whole in this one cycle
      if (ctl4[sepi_pkg::C4_FAULT_ACK]) begin
        // a fault raised this very cycle survives the acknowledge
        if (!s_next.last_frame_bad && !(new_frame && l_reg.err)) begin
          s_next.frame_fault = 1'b0; // RL19
        end
        if (!s_next.sup_lvl) begin
          s_next.supply_fault = 1'b0;
        end
      end
      // a freeze taken this very cycle outlives the acknowledge
      if (ctl4[sepi_pkg::C4_LATCH_ACK] && s_reg.frozen) begin
        s_next.frozen = 1'b0;
      end
      if (ctl4[sepi_pkg::C4_LOAD1] && ctl4[sepi_pkg::C4_LOAD2]) begin
        s_next.load_err = 1'b1; // RL18
        s_next.load_stat = 1'b0;
      end else if (ctl4[sepi_pkg::C4_LOAD1]) begin
        s_next.thr1 = ctrl_image[sepi_pkg::POS_MSB:sepi_pkg::POS_LSB];
        s_next.load_stat = 1'b1; // RL20
        s_next.load_err = 1'b0;
      end else if (ctl4[sepi_pkg::C4_LOAD2]) begin
        s_next.thr2 = ctrl_image[sepi_pkg::POS_MSB:sepi_pkg::POS_LSB];
        s_next.load_stat = 1'b1; // RL20
        s_next.load_err = 1'b0;
      end else begin
        // handshake ends once the master drops its request
        s_next.load_stat = 1'b0;
        s_next.load_err = 1'b0;
      end
      s_next.acc = acquire ? 24'h000000 : s_reg.acc + step; // RL5
      if (acquire) begin
        s_next.req_tgl = ~s_reg.req_tgl;
        s_next.mf_hold = monoflop_us;
        if (iso_mode && heartbeat_en) begin
          s_next.heartbeat = ~s_reg.heartbeat; // RL1 RL2
        end
      end
    end
    // image assembled in this process so no loop runs between two processes
    shown = s_reg.frozen ? s_reg.frozen_pos : s_reg.pos; // RL9
    shown[sepi_pkg::FROZEN_BIT] = s_reg.frozen; // RL9
    b4 = 8'h00;
    b4[sepi_pkg::B4_HEARTBEAT] = s_next.heartbeat; // RL3
    b4[sepi_pkg::B4_READY] = !config_fault; // RL10
    b4[sepi_pkg::B4_CFG_FAULT] = config_fault; // RL10
    b4[sepi_pkg::B4_FRAME_FAULT] = s_reg.frame_fault; // RL10
    b4[sepi_pkg::B4_SUPPLY] = s_reg.supply_fault; // RL10
    b4[sepi_pkg::B4_INPUT] = s_reg.aux_lvl; // RL10
    b4[sepi_pkg::B4_DOWN] = s_reg.dn; // RL10
    b4[sepi_pkg::B4_UP] = s_reg.up; // RL10
    b5 = 8'h00; // RL13
    b5[sepi_pkg::B5_HIT2] = s_reg.pos >= s_reg.thr2; // RL11
    b5[sepi_pkg::B5_HIT1] = s_reg.pos >= s_reg.thr1; // RL11
    b5[sepi_pkg::B5_LOAD_ERR] = s_next.load_err; // RL12
    b5[sepi_pkg::B5_LOAD_STAT] = s_next.load_stat; // RL12
    if (cycle_strobe) begin
      s_next.fb = {shown, b4, b5, 16'h0000}; // RL8 RL21 RL13
      if (fast_mode) begin
        s_next.fb[sepi_pkg::FAST_HB_BIT] = s_next.heartbeat; // RL3
        s_next.fb[sepi_pkg::FB_B4] = 1'b0;
      end
    end
    if (srst) begin
      s_next = '0;
    end
  end

  always_ff @(posedge clk) begin
    s_reg <= s_next;
  end

  assign fb_image = s_reg.fb;

  // ****************************************
  // serial link side
  // ****************************************
  always_comb begin
    l_next = l_reg;
    l_next.req_sync = {l_reg.req_sync[1:0], s_reg.req_tgl};
    l_next.dat_sync = {l_reg.dat_sync[1:0], ssi_data_in};
    if (l_reg.dat_sync[1] == l_reg.dat_sync[2]) begin
      l_next.dat_lvl = l_reg.dat_sync[2];
    end
    case (l_reg.st)
      sepi_pkg::SEPI_IDLE: begin
        if (l_reg.req_sync[2] != l_reg.req_sync[1]) begin
          // a resting line that is low means no encoder or a broken wire
          l_next.err = !l_reg.dat_lvl;
          // old frame bits would otherwise reach the top of the word
          l_next.shreg = 32'h00000000;
          l_next.bit_cnt = 5'h00;
          l_next.div = 3'h0;
          l_next.sclk = 1'b0;
          l_next.st = sepi_pkg::SEPI_SHIFT;
        end
      end
      sepi_pkg::SEPI_SHIFT: begin
        // slow half bits leave room for the input synchroniser delay
        l_next.div = l_reg.div + 3'h1;
        if (l_reg.div == 3'(sepi_pkg::LINK_HALF_BIT - 1)) begin
          l_next.div = 3'h0;
          l_next.sclk = ~l_reg.sclk;
          if (!l_reg.sclk) begin
            // level just accepted by the synchroniser; the registered one lags a link clock
            l_next.shreg = {l_reg.shreg[30:0], l_next.dat_lvl};
            l_next.bit_cnt = l_reg.bit_cnt + 5'h01;
            if (l_reg.bit_cnt == 5'(sepi_pkg::FRAME_BITS - 1)) begin
              l_next.data = {l_reg.shreg[30:0], l_next.dat_lvl};
              l_next.done_tgl = ~l_reg.done_tgl;
              l_next.gap_ns = 32'h00000000;
              l_next.st = sepi_pkg::SEPI_GAP;
            end
          end
        end
      end
      sepi_pkg::SEPI_GAP: begin
        l_next.sclk = 1'b1;
        l_next.gap_ns = l_reg.gap_ns + 32'(sepi_pkg::LINK_PERIOD_NS);
        // mf_hold is set with the request toggle and holds through the frame
        if (l_reg.gap_ns >= 32'(s_reg.mf_hold) * 32'(sepi_pkg::NS_PER_US)) begin
          l_next.st = sepi_pkg::SEPI_IDLE; // RL6
        end
      end
      default: begin
        l_next.st = sepi_pkg::SEPI_IDLE;
      end
    endcase
    if (link_srst) begin
      l_next = '0;
      l_next.st = sepi_pkg::SEPI_IDLE;
      l_next.sclk = 1'b1;
      // idle line is high; a low reset value would flag the first frame
      l_next.dat_sync = 3'b111;
      l_next.dat_lvl = 1'b1;
    end
  end

  always_ff @(posedge link_clk) begin
    l_reg <= l_next;
  end

  assign ssi_clk_out = l_reg.sclk;

  // ****************************************
  // checks
  // ****************************************
  property p_hb_toggle;
    @(posedge clk) disable iff (srst)
    cycle_strobe && acquire && iso_mode && heartbeat_en |=> s_reg.heartbeat != $past(s_reg.heartbeat);
  endproperty
  a_hb_toggle: assert property (p_hb_toggle) else $error("heartbeat did not invert"); // RL1

  property p_hb_hold;
    @(posedge clk) disable iff (srst)
    cycle_strobe && !acquire |=> $stable(s_reg.heartbeat);
  endproperty
  a_hb_hold: assert property (p_hb_hold) else $error("heartbeat moved in skipped cycle"); // RL2

  property p_no_limit;
    @(posedge clk) disable iff (srst)
    !iso_mode |-> acquire;
  endproperty
  a_no_limit: assert property (p_no_limit) else $error("rate limit outside isochronous"); // RL4

  property p_fb_stable;
    @(posedge clk) disable iff (srst)
    !cycle_strobe |=> $stable(fb_image);
  endproperty
  a_fb_stable: assert property (p_fb_stable) else $error("image changed between cycles"); // RL21

  property p_spare_zero;
    @(posedge clk) disable iff (srst)
    fb_image[15:0] == 16'h0000 && fb_image[sepi_pkg::FB_B5 -: 4] == 4'h0;
  endproperty
  a_spare_zero: assert property (p_spare_zero) else $error("spare bits not zero"); // RL13

  property p_both_load;
    @(posedge clk) disable iff (srst)
    cycle_strobe && ctl4[sepi_pkg::C4_LOAD1] && ctl4[sepi_pkg::C4_LOAD2]
      |=> fb_image[sepi_pkg::FB_B5 - 7 + sepi_pkg::B5_LOAD_ERR] && $stable(s_reg.thr1)
        && $stable(s_reg.thr2);
  endproperty
  a_both_load: assert property (p_both_load) else $error("double request loaded"); // RL18

  property p_load_ok;
    @(posedge clk) disable iff (srst)
    cycle_strobe && (ctl4[sepi_pkg::C4_LOAD1] ^ ctl4[sepi_pkg::C4_LOAD2])
      |=> fb_image[sepi_pkg::FB_B5 - 7 + sepi_pkg::B5_LOAD_STAT];
  endproperty
  a_load_ok: assert property (p_load_ok) else $error("load status missing"); // RL20

  property p_fault_clear;
    @(posedge clk) disable iff (srst)
    $fell(s_reg.frame_fault) |-> $past(cycle_strobe) && $past(ctl4[sepi_pkg::C4_FAULT_ACK]);
  endproperty
  a_fault_clear: assert property (p_fault_clear) else $error("frame fault cleared unasked"); // RL19

  property p_frozen_flag;
    @(posedge clk) disable iff (srst)
    cycle_strobe |=> fb_image[sepi_pkg::POS_MSB] == $past(s_reg.frozen) || fast_mode;
  endproperty
  a_frozen_flag: assert property (p_frozen_flag) else $error("frozen flag wrong"); // RL9

  property p_gap;
    @(posedge link_clk) disable iff (link_srst)
    l_reg.st == sepi_pkg::SEPI_GAP |-> l_reg.sclk;
  endproperty
  a_gap: assert property (p_gap) else $error("clock active in gap"); // RL6

  c_acquire: cover property (@(posedge clk) disable iff (srst) cycle_strobe && acquire);
  c_skip: cover property (@(posedge clk) disable iff (srst) cycle_strobe && !acquire);
  c_frame: cover property (@(posedge clk) disable iff (srst) new_frame && !l_reg.err);
  c_frozen: cover property (@(posedge clk) disable iff (srst) $rose(s_reg.frozen));
endmodule
`default_nettype wire

// [bench/sepi_encoder_model.sv]
// synchronous serial absolute encoder model
`timescale 1ns/100ps
`default_nettype none
module sepi_encoder_model #(
  parameter int ENC_MONO_NS = 1000
) (
  input wire logic sclk,
  input wire logic [24:0] pos,
  input wire logic broken,
  output logic data
);
  logic [24:0] shift_reg;
  logic data_reg;
  int cnt;
  initial begin
    shift_reg = '0;
    data_reg = 1'b1;
    cnt = 0;
  end
  // a broken wire holds the line low
  assign data = broken ? 1'b0 : data_reg;
  // first fall freezes the position, msb first
  always @(negedge sclk) begin
    if (cnt == 0) begin
      shift_reg = pos;
    end
    data_reg = shift_reg[24 - cnt];
    cnt = cnt + 1;
  end
  // own monoflop: low after the last bit, then idle high
  always @(posedge sclk) begin
    if (cnt == 25) begin
      cnt = 0;
      data_reg = 1'b0;
      #(ENC_MONO_NS) data_reg = 1'b1;
    end
  end
endmodule
`default_nettype wire

// [bench/sepi_top_tb_top.sv]
// testbench for the encoder process-data interface
`timescale 1ns/100ps
`default_nettype none
module sepi_top_tb_top;
  localparam int GAP = 1500;
  localparam int B4 = sepi_pkg::FB_B4 - 7;
  localparam int B5 = sepi_pkg::FB_B5 - 7;
  logic clk, srst, link_clk, stb, iso, fast, hb_en, latch_en;
  logic cfg_f, aux, short_p, broken, sclk, sdata, hb, tog, tog_prev;
  logic [63:0] ctrl, fb;
  logic [5:0] rate;
  logic [15:0] cyc_us, mono_us;
  logic [24:0] pos;
  int error_cnt, checks;
  sepi_top sepi_top_i (.clk(clk), .srst(srst), .link_clk(link_clk), .link_srst(srst),
    .cycle_strobe(stb), .ctrl_image(ctrl), .fb_image(fb), .iso_mode(iso), .fast_mode(fast),
    .heartbeat_en(hb_en), .latch_en(latch_en), .rate_code(rate), .cycle_time_us(cyc_us),
    .monoflop_us(mono_us), .config_fault(cfg_f), .aux_input_pin(aux),
    .supply_short_pin(short_p), .ssi_clk_out(sclk), .ssi_data_in(sdata));
  // encoder monoflop kept below the configured gap
  sepi_encoder_model #(.ENC_MONO_NS(1000)) sepi_encoder_model_i (.sclk(sclk), .pos(pos),
    .broken(broken), .data(sdata));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #3;
    forever #16 link_clk = ~link_clk;
  end
  // ******************************
  // access tasks
  // ******************************
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bit_is(input int idx, input logic v);
    cmp({63'h0, fb[idx]}, {63'h0, v});
  endtask
  // one processing cycle; the image must stand until the next strobe
  task automatic cycle(input logic [31:0] thr, input logic [7:0] req);
    logic [63:0] snap;
    @(posedge clk);
    stb <= 1'b1;
    ctrl <= {thr, req, 24'h000000};
    @(posedge clk);
    stb <= 1'b0;
    #1;
    snap = fb;
    repeat (GAP) @(posedge clk);
    cmp(fb, snap);
  endtask
  task automatic nop;
    cycle(32'h0, 8'h00);
  endtask
  task automatic give_verdict;
    $display("Checks %0d, errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #720000;
    error_cnt++;
    $display("Error at %0t: run limit reached", $time);
    give_verdict();
  end
  initial begin
    error_cnt = 0;
    checks = 0;
    srst = 1'b1;
    stb = 1'b0;
    ctrl = 64'h0;
    iso = 1'b1;
    fast = 1'b0;
    hb_en = 1'b1;
    latch_en = 1'b0;
    cfg_f = 1'b0;
    aux = 1'b0;
    short_p = 1'b0;
    broken = 1'b0;
    rate = 6'h00;
    cyc_us = 16'h0014;
    mono_us = 16'h0003;
    pos = 25'h0123456;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    cmp(fb, 64'h0);
    nop();
    for (int i = 0; i < 3; i++) begin
      hb = fb[B4 + 7];
      nop();
      bit_is(B4 + 7, ~hb);
    end
    cmp(fb & 64'hFFFF_FFFF_7CF0_FFFF, {7'h00, pos, 32'h4000_0000});
    pos <= pos + 25'h0000100;
    nop();
    nop();
    cmp(fb & 64'h0300_0000, 64'h0100_0000);
    pos <= pos - 25'h0000200;
    nop();
    nop();
    cmp(fb & 64'h0300_0000, 64'h0200_0000);
    hb_en <= 1'b0;
    nop();
    hb = fb[B4 + 7];
    nop();
    bit_is(B4 + 7, hb);
    hb_en <= 1'b1;
    iso <= 1'b0;
    nop();
    hb = fb[B4 + 7];
    nop();
    bit_is(B4 + 7, hb);
    iso <= 1'b1;
    rate <= 6'h0C;
    cyc_us <= 16'h01F4;
    for (int i = 0; i < 8; i++) begin
      if (i == 4) begin
        rate <= 6'h3F;
      end
      hb = fb[B4 + 7];
      nop();
      tog = fb[B4 + 7] ^ hb;
      if (i > 0 && i < 4) begin
        cmp({63'h0, tog}, {63'h0, ~tog_prev});
      end
      if (i > 4) begin
        cmp({63'h0, tog}, 64'h1);
      end
      tog_prev = tog;
    end
    rate <= 6'h00;
    cyc_us <= 16'h0014;
    fast <= 1'b1;
    nop();
    hb = fb[63];
    nop();
    bit_is(63, ~hb);
    bit_is(B4 + 7, 1'b0);
    fast <= 1'b0;
    cycle(32'h0000_0010, 8'h01);
    cmp(fb & 64'h0003_0000, 64'h0001_0000);
    nop();
    cmp(fb & 64'h0007_0000, 64'h0004_0000);
    cycle(32'h01FF_FFFF, 8'h03);
    bit_is(B5 + 1, 1'b1);
    nop();
    cmp(fb & 64'h0007_0000, 64'h0004_0000);
    cycle(32'h01FF_FFFF, 8'h02);
    nop();
    bit_is(B5 + 3, 1'b0);
    cycle(32'h0000_0010, 8'h02);
    nop();
    bit_is(B5 + 3, 1'b1);
    broken <= 1'b1;
    // let the low line pass the link synchroniser before the request
    repeat (40) @(posedge clk);
    nop();
    nop();
    bit_is(B4 + 4, 1'b1);
    cycle(32'h0, 8'h80);
    bit_is(B4 + 4, 1'b1);
    broken <= 1'b0;
    nop();
    nop();
    cycle(32'h0, 8'h80);
    // fault flags show the acknowledge at the following strobe
    nop();
    bit_is(B4 + 4, 1'b0);
    cfg_f <= 1'b1;
    short_p <= 1'b1;
    aux <= 1'b1;
    // pins pass four flip-flops before the image can show them
    repeat (8) @(posedge clk);
    nop();
    cmp(fb & 64'h7C00_0000, 64'h2C00_0000);
    cfg_f <= 1'b0;
    short_p <= 1'b0;
    nop();
    cycle(32'h0, 8'h80);
    nop();
    bit_is(B4 + 3, 1'b0);
    latch_en <= 1'b1;
    aux <= 1'b0;
    nop();
    aux <= 1'b1;
    nop();
    nop();
    bit_is(63, 1'b1);
    cycle(32'h0, 8'h40);
    nop();
    bit_is(63, 1'b0);
    give_verdict();
  end
endmodule
`default_nettype wire
